// File: hdl/hpt_defs.svh
// Purpose: register offsets, reset values and time-base counts of the host power timers
// Assumes: byte-wide register addresses, multi-byte values least significant byte first
// Notes:   definitions only
`ifndef HPT_DEFS_SVH
`define HPT_DEFS_SVH

`define HPT_OFF_DELAY_ADDR   8'h1c
`define HPT_LOSS_MIN_ADDR    8'h1e
`define HPT_BOOT_TO_ADDR     8'h21
`define HPT_SHDN_TO_ADDR     8'h22
`define HPT_SECONDS_ADDR     8'h28
`define HPT_WAKE_ADDR        8'h2c

`define HPT_OFF_DELAY_RST    16'h0028
`define HPT_LOSS_MIN_RST     16'hffff
`define HPT_BOOT_TO_RST      8'h1e
`define HPT_SHDN_TO_RST      8'h0c
`define HPT_SECONDS_RST      32'h0000_0000
`define HPT_WAKE_RST         32'h0000_0000

`define HPT_LOSS_DISABLED    16'hffff
`define HPT_XTAL_HZ          32768
`define HPT_TICKS_PER_SEC    8
`define HPT_SECS_PER_UNIT    10
`define HPT_SECS_PER_MIN     60
`define HPT_I2C_ADDR         7'h43

`endif

// File: hdl/hpt_i2c_slave.sv
// Purpose: byte-wide two-wire register slave with an auto-incrementing register pointer
// Assumes: scl and sda sampled on clk, far slower than clk; sda is open drain
// Notes:   first written byte after the address sets the pointer, later bytes write registers
`timescale 1ns/1ps
`default_nettype none
`include "hpt_defs.svh"

module hpt_i2c_slave
    import hpt_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `HPT_I2C_ADDR
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        scl,
    input  wire logic        sdaIn,
    output var  logic        sdaOe,
    output var  logic [7:0]  rdAddr,
    input  wire logic [7:0]  rdData,
    output var  hpt_reg_wr_t regWr
);

    hpt_bus_regs_t s_r;
    hpt_bus_regs_t s_nxt;
    logic          sclRise;
    logic          sclFall;
    logic          startSeen;
    logic          stopSeen;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sclPrev = scl;
        s_nxt.sdaPrev = sdaIn;
        s_nxt.wr.wrStb = 1'b0;
        sclRise = scl && !s_r.sclPrev;
        sclFall = !scl && s_r.sclPrev;
        startSeen = scl && s_r.sclPrev && s_r.sdaPrev && !sdaIn;
        stopSeen = scl && s_r.sclPrev && !s_r.sdaPrev && sdaIn;
        if (startSeen) begin
            s_nxt.st = BUS_ADDR;
            s_nxt.bitCnt = 4'h0;
            s_nxt.sdaOe = 1'b0;
            s_nxt.firstByte = 1'b1;
        end else if (stopSeen) begin
            s_nxt.st = BUS_IDLE;
            s_nxt.sdaOe = 1'b0;
        end else begin
            unique case (s_r.st)
                BUS_IDLE: begin
                    s_nxt.sdaOe = 1'b0;
                end
                BUS_ADDR, BUS_RX: begin
                    if (sclRise) begin
                        s_nxt.shift = {s_r.shift[6:0], sdaIn};
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end else if (sclFall && s_r.bitCnt == 4'h8) begin
                        s_nxt.bitCnt = 4'h0;
                        if (s_r.st == BUS_ADDR) begin
                            if (s_r.shift[7:1] == DEV_ADDR) begin
                                s_nxt.rw = s_r.shift[0];
                                s_nxt.st = BUS_ACK;
                                s_nxt.sdaOe = 1'b1;
                            end else begin
                                s_nxt.st = BUS_IDLE;
                            end
                        end else begin
                            s_nxt.st = BUS_ACK;
                            s_nxt.sdaOe = 1'b1;
                            if (s_r.firstByte) begin
                                s_nxt.ptr = s_r.shift;
                                s_nxt.firstByte = 1'b0;
                            end else begin
                                // consecutive bytes land at consecutive addresses
                                s_nxt.wr.wrStb = 1'b1;
                                s_nxt.wr.addr = s_r.ptr;
                                s_nxt.wr.data = s_r.shift;
                                s_nxt.ptr = s_r.ptr + 8'h01;
                            end
                        end
                    end
                end
                BUS_ACK: begin
                    if (sclFall) begin
                        if (s_r.rw) begin
                            s_nxt.st = BUS_TX;
                            s_nxt.shift = rdData;
                            s_nxt.sdaOe = !rdData[7];
                            s_nxt.ptr = s_r.ptr + 8'h01;
                        end else begin
                            s_nxt.st = BUS_RX;
                            s_nxt.sdaOe = 1'b0;
                        end
                    end
                end
                BUS_TX: begin
                    if (sclFall) begin
                        if (s_r.bitCnt == 4'h7) begin
                            s_nxt.st = BUS_RACK;
                            s_nxt.sdaOe = 1'b0;
                            s_nxt.bitCnt = 4'h0;
                        end else begin
                            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                            s_nxt.shift = {s_r.shift[6:0], 1'b0};
                            s_nxt.sdaOe = !s_r.shift[6];
                        end
                    end
                end
                BUS_RACK: begin
                    if (sclRise) begin
                        s_nxt.nack = sdaIn;
                    end else if (sclFall) begin
                        if (s_r.nack) begin
                            s_nxt.st = BUS_IDLE;
                        end else begin
                            // next byte of a multi-byte read, low byte went first
                            s_nxt.st = BUS_TX;
                            s_nxt.shift = rdData;
                            s_nxt.sdaOe = !rdData[7];
                            s_nxt.ptr = s_r.ptr + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sdaOe  = s_r.sdaOe;
    assign rdAddr = s_r.ptr;
    assign regWr  = s_r.wr;

endmodule
`default_nettype wire

// File: hdl/hpt_pkg.sv
// Purpose: types shared by the host power timer files
// Assumes: nothing
// Notes:   widths of the bus engine state are fixed by the byte protocol
package hpt_pkg;

    typedef enum logic [1:0] {PM_OFF, PM_BOOT, PM_RUN, PM_SHDN} hpt_pm_state_t;

    typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_RX, BUS_ACK, BUS_TX, BUS_RACK} hpt_bus_state_t;

    typedef struct packed {
        logic       txLine;
        logic       currentBelow;
        logic       inputPresent;
        logic       batteryLow;
    } hpt_sense_t;

    typedef struct packed {
        logic       wrStb;
        logic [7:0] addr;
        logic [7:0] data;
    } hpt_reg_wr_t;

    typedef struct packed {
        hpt_bus_state_t st;
        logic [3:0]     bitCnt;
        logic [7:0]     shift;
        logic           rw;
        logic           firstByte;
        logic           nack;
        logic [7:0]     ptr;
        logic           sdaOe;
        logic           sclPrev;
        logic           sdaPrev;
        hpt_reg_wr_t    wr;
    } hpt_bus_regs_t;

    typedef struct packed {
        hpt_pm_state_t st;
        logic [15:0]   offDelay;
        logic [15:0]   lossMin;
        logic [7:0]    bootTo;
        logic [7:0]    shdnTo;
        logic [31:0]   seconds;
        logic [31:0]   wake;
        logic          xtalPrev;
        logic [11:0]   tickDiv;
        logic [2:0]    tickInSec;
        logic [3:0]    secInUnit;
        logic [5:0]    secInMin;
        logic [7:0]    unitCnt;
        logic [15:0]   minCnt;
        logic [15:0]   delayCnt;
        logic          delayRun;
        logic          hostPower;
        logic          shdnReq;
    } hpt_pm_regs_t;

endpackage

// File: hdl/hpt_power_timers.sv
// Purpose: host power sequencing timers, seconds counter and wake alarm behind a two-wire register port
// Assumes: all inputs synchronous to clk; xtalClk is the 32 kHz time base sampled as a level
// Notes:   tick, unit and minute timing is approximate, the prescaler free-runs
//
// Overview of operation
// - wait power-off delay plus one ticks, then cut power
// - shutdown seen: transmit low or current low
// - system tick runs eight per second
// - input loss starts shutdown after set minutes
// - all-ones minutes disables auto shutdown
// - zero minutes shuts down immediately
// - low battery overrides input-loss delay
// - boot timeout in ten-second units, default thirty
// - zero boot timeout disables it
// - shutdown timeout ten-second units, default twelve
// - zero shutdown timeout disables it
// - 32-bit seconds from crystal, always running
// - seconds start at zero, host may load
// - wake when seconds reach or pass alarm
// - missed alarm reboots right after shutdown
// - alarm boot clears alarm, others keep it
// - two-byte registers low byte first, consecutive
`timescale 1ns/1ps
`default_nettype none
`include "hpt_defs.svh"

module hpt_power_timers
    import hpt_pkg::*;
#(
    parameter int         XTAL_HZ       = `HPT_XTAL_HZ,
    parameter int         TICKS_PER_SEC = `HPT_TICKS_PER_SEC,
    parameter logic [6:0] DEV_ADDR      = `HPT_I2C_ADDR
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output var  logic       sdaOut,
    output var  logic       sdaOe,
    input  wire logic       xtalClk,
    input  wire hpt_sense_t sense,
    input  wire logic       bootCmd,
    input  wire logic       hostBooted,
    input  wire logic       shutdownCmd,
    output var  logic       hostPowerOn,
    output var  logic       shutdownRequest
);

    localparam int XTAL_PER_TICK = XTAL_HZ / TICKS_PER_SEC;

    hpt_pm_regs_t s_r;
    hpt_pm_regs_t s_nxt;
    hpt_reg_wr_t  regWr;
    logic [7:0]   rdAddr;
    logic [7:0]   rdData;
    logic         xtalRise;
    logic         tick;
    logic         secPulse;
    logic         unitPulse;
    logic         minPulse;
    logic         hostDone;
    logic         alarmHit;
    logic         secondsWr;

    hpt_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_bus (
        .clk    (clk),
        .rst    (rst),
        .scl    (scl),
        .sdaIn  (sdaIn),
        .sdaOe  (sdaOe),
        .rdAddr (rdAddr),
        .rdData (rdData),
        .regWr  (regWr)
    );

    // the pin only ever pulls low
    assign sdaOut = 1'b0;

    // multi-byte values read low byte at the lower address
    always_comb begin
        unique case (rdAddr)
            `HPT_OFF_DELAY_ADDR:         rdData = s_r.offDelay[7:0];
            `HPT_OFF_DELAY_ADDR + 8'h01: rdData = s_r.offDelay[15:8];
            `HPT_LOSS_MIN_ADDR:          rdData = s_r.lossMin[7:0];
            `HPT_LOSS_MIN_ADDR + 8'h01:  rdData = s_r.lossMin[15:8];
            `HPT_BOOT_TO_ADDR:           rdData = s_r.bootTo;
            `HPT_SHDN_TO_ADDR:           rdData = s_r.shdnTo;
            `HPT_SECONDS_ADDR:           rdData = s_r.seconds[7:0];
            `HPT_SECONDS_ADDR + 8'h01:   rdData = s_r.seconds[15:8];
            `HPT_SECONDS_ADDR + 8'h02:   rdData = s_r.seconds[23:16];
            `HPT_SECONDS_ADDR + 8'h03:   rdData = s_r.seconds[31:24];
            `HPT_WAKE_ADDR:              rdData = s_r.wake[7:0];
            `HPT_WAKE_ADDR + 8'h01:      rdData = s_r.wake[15:8];
            `HPT_WAKE_ADDR + 8'h02:      rdData = s_r.wake[23:16];
            `HPT_WAKE_ADDR + 8'h03:      rdData = s_r.wake[31:24];
            default:                     rdData = 8'h00;
        endcase
    end

    always_comb begin
        xtalRise = xtalClk && !s_r.xtalPrev;
        tick = xtalRise && (s_r.tickDiv == 12'(XTAL_PER_TICK - 1));
        secPulse = tick && (s_r.tickInSec == 3'(TICKS_PER_SEC - 1));
        unitPulse = secPulse && (s_r.secInUnit == 4'(`HPT_SECS_PER_UNIT - 1));
        minPulse = secPulse && (s_r.secInMin == 6'(`HPT_SECS_PER_MIN - 1));
        hostDone = !sense.txLine || sense.currentBelow;
        // zero means no alarm armed, else it would fire forever
        alarmHit = (s_r.wake != 32'h0000_0000) && (s_r.seconds >= s_r.wake);
        secondsWr = regWr.wrStb && (regWr.addr[7:2] == 6'(`HPT_SECONDS_ADDR >> 2));
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.xtalPrev = xtalClk;

        // free-running time base, keeps going with host off
        if (xtalRise) begin
            s_nxt.tickDiv = tick ? 12'h000 : s_r.tickDiv + 12'h001;
        end
        if (tick) begin
            s_nxt.tickInSec = secPulse ? 3'h0 : s_r.tickInSec + 3'h1;
        end
        if (secPulse) begin
            s_nxt.seconds = s_r.seconds + 32'h0000_0001;
            s_nxt.secInUnit = unitPulse ? 4'h0 : s_r.secInUnit + 4'h1;
            s_nxt.secInMin = minPulse ? 6'h00 : s_r.secInMin + 6'h01;
        end
        if (unitPulse && s_r.unitCnt != 8'hff) begin
            s_nxt.unitCnt = s_r.unitCnt + 8'h01;
        end
        if (minPulse && s_r.minCnt != 16'hffff) begin
            s_nxt.minCnt = s_r.minCnt + 16'h0001;
        end

        unique case (s_r.st)
            PM_OFF: begin
                s_nxt.hostPower = 1'b0;
                s_nxt.shdnReq = 1'b0;
                // checked on entry too, so a missed alarm reboots at once
                if (alarmHit || bootCmd) begin
                    s_nxt.st = PM_BOOT;
                    s_nxt.hostPower = 1'b1;
                    s_nxt.unitCnt = 8'h00;
                    if (alarmHit) begin
                        s_nxt.wake = 32'h0000_0000;
                    end
                end
            end
            PM_BOOT: begin
                if (hostBooted) begin
                    s_nxt.st = PM_RUN;
                    s_nxt.minCnt = 16'h0000;
                end else if (s_r.bootTo != 8'h00 && s_r.unitCnt >= s_r.bootTo) begin
                    s_nxt.st = PM_OFF;
                    s_nxt.hostPower = 1'b0;
                end
            end
            PM_RUN: begin
                if (sense.inputPresent) begin
                    s_nxt.minCnt = 16'h0000;
                end
                if (sense.batteryLow || shutdownCmd ||
                    (!sense.inputPresent && s_r.lossMin != `HPT_LOSS_DISABLED &&
                     s_r.minCnt >= s_r.lossMin)) begin
                    s_nxt.st = PM_SHDN;
                    s_nxt.shdnReq = 1'b1;
                    s_nxt.unitCnt = 8'h00;
                    s_nxt.delayRun = 1'b0;
                end
            end
            PM_SHDN: begin
                if (!hostDone) begin
                    s_nxt.delayRun = 1'b0;
                end else if (!s_r.delayRun) begin
                    s_nxt.delayRun = 1'b1;
                    s_nxt.delayCnt = s_r.offDelay;
                end else if (tick) begin
                    s_nxt.delayCnt = s_r.delayCnt - 16'h0001;
                end
                if (hostBooted && !hostDone) begin
                    s_nxt.st = PM_RUN;
                    s_nxt.shdnReq = 1'b0;
                    s_nxt.minCnt = 16'h0000;
                end else if ((hostDone && s_r.delayRun && tick && s_r.delayCnt == 16'h0000) ||
                             (s_r.shdnTo != 8'h00 && s_r.unitCnt >= s_r.shdnTo)) begin
                    s_nxt.st = PM_OFF;
                    s_nxt.hostPower = 1'b0;
                    s_nxt.shdnReq = 1'b0;
                    s_nxt.delayRun = 1'b0;
                end
            end
        endcase

        // host writes win over counting in the same cycle
        if (regWr.wrStb) begin
            unique case (regWr.addr)
                `HPT_OFF_DELAY_ADDR:         s_nxt.offDelay[7:0] = regWr.data;
                `HPT_OFF_DELAY_ADDR + 8'h01: s_nxt.offDelay[15:8] = regWr.data;
                `HPT_LOSS_MIN_ADDR:          s_nxt.lossMin[7:0] = regWr.data;
                `HPT_LOSS_MIN_ADDR + 8'h01:  s_nxt.lossMin[15:8] = regWr.data;
                `HPT_BOOT_TO_ADDR:           s_nxt.bootTo = regWr.data;
                `HPT_SHDN_TO_ADDR:           s_nxt.shdnTo = regWr.data;
                `HPT_SECONDS_ADDR:           s_nxt.seconds[7:0] = regWr.data;
                `HPT_SECONDS_ADDR + 8'h01:   s_nxt.seconds[15:8] = regWr.data;
                `HPT_SECONDS_ADDR + 8'h02:   s_nxt.seconds[23:16] = regWr.data;
                `HPT_SECONDS_ADDR + 8'h03:   s_nxt.seconds[31:24] = regWr.data;
                `HPT_WAKE_ADDR:              s_nxt.wake[7:0] = regWr.data;
                `HPT_WAKE_ADDR + 8'h01:      s_nxt.wake[15:8] = regWr.data;
                `HPT_WAKE_ADDR + 8'h02:      s_nxt.wake[23:16] = regWr.data;
                `HPT_WAKE_ADDR + 8'h03:      s_nxt.wake[31:24] = regWr.data;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= PM_OFF;
            s_r.offDelay <= `HPT_OFF_DELAY_RST;
            s_r.lossMin <= `HPT_LOSS_MIN_RST;
            s_r.bootTo <= `HPT_BOOT_TO_RST;
            s_r.shdnTo <= `HPT_SHDN_TO_RST;
            s_r.seconds <= `HPT_SECONDS_RST;
            s_r.wake <= `HPT_WAKE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hostPowerOn     = s_r.hostPower;
    assign shutdownRequest = s_r.shdnReq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_DELAY_RELOAD: assert property (
        s_r.st == PM_SHDN && hostDone && !s_r.delayRun && !hostBooted
        |=> s_r.delayRun && s_r.delayCnt == $past(s_r.offDelay))
        else $error("power-off delay not reloaded on detection");

    AST_TX_ABORT: assert property (
        s_r.st == PM_SHDN && !hostDone |=> !s_r.delayRun)
        else $error("power-off delay kept running with transmit high");

    AST_DETECT_CURRENT: assert property (
        s_r.st == PM_SHDN && sense.txLine && sense.currentBelow && !s_r.delayRun
        |=> s_r.delayRun)
        else $error("low current not taken as shutdown done");

    AST_DELAY_EXPIRE: assert property (
        s_r.st == PM_SHDN && hostDone && s_r.delayRun && tick && s_r.delayCnt == 16'h0000
        |=> s_r.st == PM_OFF && !hostPowerOn)
        else $error("power not cut when delay ran out");

    AST_TICK_SPACING: assert property (
        tick |=> !tick [*8])
        else $error("system ticks too close together");

    AST_SECONDS_STEP: assert property (
        secPulse && !secondsWr |=> s_r.seconds == $past(s_r.seconds) + 32'h0000_0001)
        else $error("seconds counter did not advance");

    AST_SECONDS_HOLD: assert property (
        !secPulse && !secondsWr |=> $stable(s_r.seconds))
        else $error("seconds counter moved without a second");

    AST_LOSS_OFF: assert property (
        s_r.st == PM_RUN && s_r.lossMin == `HPT_LOSS_DISABLED && !sense.batteryLow && !shutdownCmd
        |=> s_r.st == PM_RUN)
        else $error("auto shutdown fired while disabled");

    AST_LOSS_ZERO: assert property (
        s_r.st == PM_RUN && !sense.inputPresent && s_r.lossMin == 16'h0000
        |=> s_r.st == PM_SHDN && shutdownRequest)
        else $error("zero input-loss time did not shut down at once");

    AST_BATTERY_LOW: assert property (
        s_r.st == PM_RUN && sense.batteryLow |=> s_r.st == PM_SHDN)
        else $error("low battery did not start shutdown");

    AST_BOOT_NO_TIMEOUT: assert property (
        s_r.st == PM_BOOT && s_r.bootTo == 8'h00 && !hostBooted |=> s_r.st == PM_BOOT)
        else $error("boot left with timeout disabled");

    AST_SHDN_TIMEOUT: assert property (
        s_r.st == PM_SHDN && s_r.shdnTo != 8'h00 && s_r.unitCnt >= s_r.shdnTo && !hostBooted
        |=> s_r.st == PM_OFF && !hostPowerOn)
        else $error("shutdown timeout did not cut power");

    AST_ALARM_WAKE: assert property (
        s_r.st == PM_OFF && alarmHit && !regWr.wrStb
        |=> s_r.st == PM_BOOT && hostPowerOn && s_r.wake == 32'h0000_0000)
        else $error("alarm did not boot host and clear itself");

endmodule
`default_nettype wire

// File: tb/hpt_host_model.sv
// Purpose: host side two-wire master for register reads and writes
// Assumes: sda pulled up and resolved by the bench; 4 clk per step, scl low 8 clk and high 4 clk per bit
// Notes:   scl falls before sda moves, so no false start or stop
`timescale 1ns/1ps
`default_nettype none
module hpt_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic hostOe
);
    initial begin
        scl = 1'b1;
        hostOe = 1'b0;
    end
    task automatic step(input logic c, input logic o);
        scl = c;
        hostOe = o;
        repeat (4) @(negedge clk);
    endtask
    task automatic start;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic bitx(input logic b, output logic r);
        step(1'b0, hostOe);
        step(1'b0, ~b);
        step(1'b1, ~b);
        r = sda;
    endtask
    task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(a, k);
    endtask
    task automatic wr(input logic [7:0] ad, input int n, input logic [31:0] d);
        logic [7:0] q;
        start();
        xb(8'h86, 1'b1, q);
        xb(ad, 1'b1, q);
        for (int i = 0; i < n; i++) xb(d[8*i+:8], 1'b1, q);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic rd(input logic [7:0] ad, input int n, output logic [31:0] v);
        logic [7:0] q;
        v = 32'h0;
        start();
        xb(8'h86, 1'b1, q);
        xb(ad, 1'b1, q);
        start();
        xb(8'h87, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            xb(8'hff, i == n - 1, q);
            v[8*i+:8] = q;
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// File: tb/hpt_power_timers_tb_top.sv
// Purpose: register and power sequencing tests of the host power timers
// Assumes: 64 Hz crystal, so tick 32 clk, second 256 clk, unit 2560 clk
// Notes:   tick timing is loose, checks allow one tick of slack
`timescale 1ns/1ps
`default_nettype none
module hpt_power_timers_tb_top;
    import hpt_pkg::*;
    logic clk, rst, scl, hostOe, sdaOe, xtalEn, bootCmd, hostBooted, shutdownCmd;
    logic hostPowerOn, shutdownRequest, sda, sdaOut;
    logic [1:0]  xc = 2'h0;
    logic [31:0] v;
    hpt_sense_t  sense;
    int          mismatches, n_tests;
    logic [7:0]  ad[6] = '{8'h1c, 8'h1e, 8'h21, 8'h22, 8'h28, 8'h2c};
    int          nb[6] = '{2, 2, 1, 1, 4, 4};
    logic [31:0] ex[6] = '{32'h28, 32'hffff, 32'h1e, 32'h0c, 32'h0, 32'h0};
    assign sda = ~(sdaOe | hostOe);
    hpt_power_timers #(.XTAL_HZ(64)) hpt_power_timers_inst (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .xtalClk(xc[1]), .sense(sense), .bootCmd(bootCmd), .hostBooted(hostBooted),
        .shutdownCmd(shutdownCmd), .hostPowerOn(hostPowerOn), .shutdownRequest(shutdownRequest));
    hpt_host_model hpt_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .hostOe(hostOe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) if (xtalEn) xc <= xc + 2'h1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic waitPw(input logic p, input int lim, input string nm);
        for (int k = 0; k < lim && hostPowerOn !== p; k++) @(negedge clk);
        chk(hostPowerOn, p, nm);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic toRun;
        sense.txLine = 1'b1;
        bootCmd = 1'b1;
        cyc(1);
        bootCmd = 1'b0;
        cyc(2);
        hostBooted = 1'b1;
        cyc(1);
        hostBooted = 1'b0;
        cyc(2);
    endtask
    task automatic shd;
        shutdownCmd = 1'b1;
        cyc(1);
        shutdownCmd = 1'b0;
        cyc(2);
    endtask
    initial begin
        #400000;
        mismatches++;
        results();
    end
    initial begin
        {rst, xtalEn, bootCmd, hostBooted, shutdownCmd} = 5'h10;
        sense = '{txLine: 1'b1, currentBelow: 1'b0, inputPresent: 1'b1, batteryLow: 1'b0};
        cyc(12);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            hpt_host_model_inst.rd(ad[i], nb[i], v);
            chk(v, ex[i], "reset value");
        end
        hpt_host_model_inst.wr(8'h28, 4, 32'h1234_5678);
        hpt_host_model_inst.wr(8'h29, 1, 32'hab);
        hpt_host_model_inst.rd(8'h28, 4, v);
        chk(v, 32'h1234_ab78, "seconds load");
        xtalEn = 1'b1;
        cyc(600);
        hpt_host_model_inst.rd(8'h28, 4, v);
        chk(v > 32'h1234_ab79 && v < 32'h1234_ab7d, 1'b1, "seconds count");
        chk(sdaOut, 1'b0, "sda drive level");
        $display("test registers done");
        hpt_host_model_inst.wr(8'h1c, 2, 32'h3);
        toRun();
        sense.inputPresent = 1'b0;
        cyc(100);
        chk(shutdownRequest, 1'b0, "loss disabled");
        sense.inputPresent = 1'b1;
        shd();
        chk(shutdownRequest, 1'b1, "shutdown request");
        sense.txLine = 1'b0;
        cyc(40);
        sense.txLine = 1'b1;
        cyc(200);
        chk(hostPowerOn, 1'b1, "delay abort");
        sense.txLine = 1'b0;
        cyc(80);
        chk(hostPowerOn, 1'b1, "delay early");
        waitPw(1'b0, 200, "delay end");
        $display("test delay done");
        hpt_host_model_inst.wr(8'h1e, 2, 32'h0);
        toRun();
        sense.inputPresent = 1'b0;
        cyc(3);
        chk(shutdownRequest, 1'b1, "loss zero");
        sense.inputPresent = 1'b1;
        sense.txLine = 1'b0;
        waitPw(1'b0, 300, "loss off");
        toRun();
        sense.batteryLow = 1'b1;
        cyc(3);
        chk(shutdownRequest, 1'b1, "battery low");
        sense.batteryLow = 1'b0;
        sense.currentBelow = 1'b1;
        waitPw(1'b0, 300, "current low");
        sense.currentBelow = 1'b0;
        $display("test shutdown causes done");
        hpt_host_model_inst.wr(8'h21, 1, 32'h1);
        bootCmd = 1'b1;
        cyc(1);
        bootCmd = 1'b0;
        cyc(2);
        chk(hostPowerOn, 1'b1, "boot on");
        waitPw(1'b0, 3000, "boot timeout");
        hpt_host_model_inst.wr(8'h21, 2, 32'h0100);
        bootCmd = 1'b1;
        cyc(1);
        bootCmd = 1'b0;
        cyc(3000);
        chk(hostPowerOn, 1'b1, "boot timeout off");
        toRun();
        shd();
        waitPw(1'b0, 3000, "shutdown timeout");
        hpt_host_model_inst.wr(8'h22, 1, 32'h0);
        toRun();
        shd();
        cyc(3000);
        chk(hostPowerOn, 1'b1, "shutdown timeout off");
        hpt_host_model_inst.wr(8'h1c, 2, 32'h64);
        sense.txLine = 1'b0;
        cyc(1000);
        sense.txLine = 1'b1;
        hostBooted = 1'b1;
        cyc(1);
        hostBooted = 1'b0;
        cyc(2);
        chk(shutdownRequest, 1'b0, "reboot");
        chk(hostPowerOn, 1'b1, "reboot power");
        hpt_host_model_inst.wr(8'h1c, 2, 32'h3);
        $display("test timeouts done");
        toRun();
        hpt_host_model_inst.wr(8'h2c, 4, 32'h1);
        shd();
        sense.txLine = 1'b0;
        waitPw(1'b0, 300, "alarm off");
        waitPw(1'b1, 20, "alarm reboot");
        sense.txLine = 1'b1;
        hpt_host_model_inst.rd(8'h2c, 4, v);
        chk(v, 32'h0, "alarm cleared");
        $display("test alarm done");
        results();
    end
endmodule
`default_nettype wire
